// ===== hdl/ppsb_top.sv
// Purpose: Parallel port pin enables and slave byte buffer status over APB
// Assumes: Master strobes are synchronous to pclk after two flops
// Notes: Four input and four output byte buffers, sticky irq flags
`timescale 1ns/1ps
`default_nettype none
module ppsb_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pm_wr_strobe,
   input wire logic pm_rd_strobe,
   input wire logic [1:0] pm_addr,
   input wire logic [7:0] pm_wdata,
   output logic [7:0] pm_rdata,
   output logic [15:0] pin_to_port,
   output logic address_line_fourteen_sel,
   output logic chip_select_one_sel,
   output logic address_latch_strobe_sel,
   output logic irq
);
   import ppsb_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [31:0] pin_en;
      logic [31:0] ctrl;
      logic [3:0] in_full;
      logic [3:0] out_empty;
      logic in_ovf;
      logic out_unf;
      logic [3:0][7:0] in_buf;
      logic [3:0][7:0] out_buf;
      logic [7:0] rdata;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic [31:0] prdata;
      logic [2:0] wr_sync;
      logic [2:0] rd_sync;
      logic [1:0][1:0] addr_sync;
      logic [1:0][7:0] wdat_sync;
   } ppsb_state_t;

   ppsb_state_t st_ff;
   ppsb_state_t nxt_st;

   logic apb_acc;
   logic apb_wr;
   logic apb_rd;
   logic slave_mode;
   logic m_wr;
   logic m_rd;
   logic [1:0] m_addr;
   logic [7:0] m_wdata;
   logic [31:0] status_word;
   logic [31:0] rd_word;
   logic rd_hit;

   function automatic logic [1:0] sel_index(input logic [31:0] d);
      sel_index = d[9:8];
   endfunction : sel_index

   ////////////////////////////////////////////////////////////////////////
   ppsb_pin_mux u_pin_mux (
      .pin_enable(st_ff.pin_en),
      .chip_select_function(st_ff.ctrl[CTL_CSF_LSB +: 2]),
      .address_data_multiplex_mode(st_ff.ctrl[CTL_MUX_LSB +: 2]),
      .pin_to_port(pin_to_port),
      .address_line_fourteen_sel(address_line_fourteen_sel),
      .chip_select_one_sel(chip_select_one_sel),
      .address_latch_strobe_sel(address_latch_strobe_sel)
   );

   ////////////////////////////////////////////////////////////////////////
   assign apb_acc = psel && penable;
   assign apb_wr = apb_acc && pwrite;
   assign apb_rd = apb_acc && !pwrite;
   assign slave_mode = st_ff.ctrl[CTL_MODE_LSB +: 2] != MODE_MASTER;
   // Edges are taken from stage two and three only
   assign m_wr = st_ff.wr_sync[1] && !st_ff.wr_sync[2];
   assign m_rd = st_ff.rd_sync[1] && !st_ff.rd_sync[2];
   assign m_addr = st_ff.addr_sync[1];
   assign m_wdata = st_ff.wdat_sync[1];

   always_comb begin
      status_word = 32'h0000_0000;
      if (slave_mode) begin
         status_word[BIT_IBF] = &st_ff.in_full;
         status_word[BIT_INPUT_OVERFLOW] = st_ff.in_ovf;
         status_word[11:8] = st_ff.in_full;
         status_word[BIT_OBE] = &st_ff.out_empty;
         status_word[BIT_OUTPUT_UNDERFLOW] = st_ff.out_unf;
         status_word[3:0] = st_ff.out_empty;
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      if (paddr == OFS_PIN_ENABLE) begin
         rd_word = st_ff.pin_en;
      end else if (paddr == OFS_STATUS) begin
         rd_word = status_word;
      end else if (paddr == OFS_CONTROL) begin
         rd_word = st_ff.ctrl;
      end else if (paddr == OFS_IN_DATA) begin
         rd_word = {24'h000000, st_ff.in_buf[sel_index(pwdata)]};
      end else if (paddr == OFS_OUT_DATA) begin
         rd_word = 32'h0000_0000;
      end else if (paddr == OFS_IRQ_STAT) begin
         rd_word = {28'h0000000, st_ff.irq_stat};
      end else if (paddr == OFS_IRQ_MASK) begin
         rd_word = {28'h0000000, st_ff.irq_mask};
      end else begin
         rd_hit = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Buffer index rides in pwdata[9:8] for both data ports
   logic [3:0] ev_set;
   logic [1:0] in_rd_idx;
   logic [1:0] out_wr_idx;
   assign in_rd_idx = pwdata[9:8];
   assign out_wr_idx = pwdata[9:8];

   always_comb begin
      nxt_st = st_ff;
      ev_set = 4'h0;
      nxt_st.wr_sync = {st_ff.wr_sync[1:0], pm_wr_strobe};
      nxt_st.rd_sync = {st_ff.rd_sync[1:0], pm_rd_strobe};
      nxt_st.addr_sync = {st_ff.addr_sync[0], pm_addr};
      nxt_st.wdat_sync = {st_ff.wdat_sync[0], pm_wdata};
      // Software side, taken at the access phase
      if (apb_wr) begin
         if (paddr == OFS_PIN_ENABLE) begin
            nxt_st.pin_en = pwdata & PIN_ENABLE_MASK;
         end else if (paddr == OFS_CONTROL) begin
            nxt_st.ctrl = pwdata & CONTROL_MASK;
         end else if (paddr == OFS_STATUS) begin
            // Writing zero clears the sticky error flags
            if (!pwdata[BIT_INPUT_OVERFLOW]) begin
               nxt_st.in_ovf = 1'b0;
            end
            if (!pwdata[BIT_OUTPUT_UNDERFLOW]) begin
               nxt_st.out_unf = 1'b0;
            end
         end else if (paddr == OFS_OUT_DATA) begin
            nxt_st.out_buf[out_wr_idx] = pwdata[7:0];
            nxt_st.out_empty[out_wr_idx] = 1'b0;
         end else if (paddr == OFS_IRQ_STAT) begin
            nxt_st.irq_stat = st_ff.irq_stat & ~pwdata[3:0];
         end else if (paddr == OFS_IRQ_MASK) begin
            nxt_st.irq_mask = pwdata[3:0] & IRQ_MASK_BITS;
         end
      end
      // In-data read selects buffer by pwdata[9:8]; master must hold pwdata
      if (apb_rd && paddr == OFS_IN_DATA) begin
         nxt_st.in_full[in_rd_idx] = 1'b0;
      end
      // Master side; hardware sets win over software clears
      if (slave_mode && m_wr) begin
         if (st_ff.in_full[m_addr]) begin
            nxt_st.in_ovf = 1'b1;
            ev_set[0] = 1'b1;
         end else begin
            nxt_st.in_buf[m_addr] = m_wdata;
            nxt_st.in_full[m_addr] = 1'b1;
            ev_set[2] = 1'b1;
         end
      end
      if (slave_mode && m_rd) begin
         nxt_st.rdata = st_ff.out_buf[m_addr];
         if (st_ff.out_empty[m_addr]) begin
            nxt_st.out_unf = 1'b1;
            ev_set[1] = 1'b1;
         end else begin
            nxt_st.out_empty[m_addr] = 1'b1;
            ev_set[3] = 1'b1;
         end
      end
      nxt_st.irq_stat = nxt_st.irq_stat | ev_set;
      if (apb_rd) begin
         nxt_st.prdata = rd_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
         st_ff.out_empty <= STATUS_RESET[3:0];
         st_ff.pin_en <= PIN_ENABLE_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Zero-wait slave; read data is combinational so it meets the same edge
   assign pready = 1'b1;
   assign pslverr = apb_acc && !rd_hit;
   assign prdata = apb_rd ? rd_word : 32'h0000_0000;
   assign pm_rdata = st_ff.rdata;
   assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

   ////////////////////////////////////////////////////////////////////////
   a_ibf_summary: assert property (@(posedge pclk) disable iff (!presetn)
      (slave_mode && &st_ff.in_full) |-> status_word[BIT_IBF])
      else $error("all-full summary missing");
   a_obe_summary: assert property (@(posedge pclk) disable iff (!presetn)
      status_word[BIT_OBE] |-> (slave_mode && &st_ff.out_empty))
      else $error("all-empty summary wrong");
   a_ovf_set: assert property (@(posedge pclk) disable iff (!presetn)
      (slave_mode && m_wr && st_ff.in_full[m_addr]) |=> st_ff.in_ovf)
      else $error("overflow not flagged");
   a_unf_set: assert property (@(posedge pclk) disable iff (!presetn)
      (slave_mode && m_rd && st_ff.out_empty[m_addr]) |=> st_ff.out_unf)
      else $error("underflow not flagged");
   a_ovf_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      (st_ff.in_ovf && !(apb_wr && paddr == OFS_STATUS)) |=> st_ff.in_ovf)
      else $error("overflow dropped");
   a_in_fill: assert property (@(posedge pclk) disable iff (!presetn)
      (slave_mode && m_wr && !st_ff.in_full[m_addr]) |=> st_ff.in_full[$past(m_addr)])
      else $error("input full not set");
   a_out_load: assert property (@(posedge pclk) disable iff (!presetn)
      (apb_wr && paddr == OFS_OUT_DATA && !(slave_mode && m_rd)) |=> !st_ff.out_empty[$past(out_wr_idx)])
      else $error("output empty not cleared");
   a_status_gated: assert property (@(posedge pclk) disable iff (!presetn)
      !slave_mode |-> (status_word == 32'h0000_0000))
      else $error("status shown outside slave mode");
   a_pin_fourteen: assert property (@(posedge pclk) disable iff (!presetn)
      (apb_wr && paddr == OFS_PIN_ENABLE) |=> (pin_to_port[14] == $past(pwdata[BIT_HIGH_SELECT_PIN_ENABLE])))
      else $error("pin fourteen enable wrong");

   ////////////////////////////////////////////////////////////////////////
   // Pin hand-over and pin function selection
   a_low_pins: assert property (@(posedge pclk) disable iff (!presetn)
      (apb_wr && paddr == OFS_PIN_ENABLE) |=> (pin_to_port[1:0] == $past(pwdata[1:0])))
      else $error("low address pins wrong");
   a_mid_pins: assert property (@(posedge pclk) disable iff (!presetn)
      (apb_wr && paddr == OFS_PIN_ENABLE) |=> (pin_to_port[10:2] == $past(pwdata[10:2])))
      else $error("middle address pins wrong");
   a_spare_pins: assert property (@(posedge pclk) disable iff (!presetn)
      (!pin_to_port[15] && pin_to_port[13:11] == 3'h0))
      else $error("unused pin handed to port");
   a_a14_select: assert property (@(posedge pclk) disable iff (!presetn)
      address_line_fourteen_sel |-> (pin_to_port[14] && st_ff.ctrl[CTL_CSF_LSB +: 2] == CSF_ADDR14))
      else $error("address fourteen chosen wrongly");
   a_cs_select: assert property (@(posedge pclk) disable iff (!presetn)
      chip_select_one_sel |-> (pin_to_port[14] && st_ff.ctrl[CTL_CSF_LSB +: 2] != CSF_ADDR14))
      else $error("chip select chosen wrongly");
   a_strobe_mode: assert property (@(posedge pclk) disable iff (!presetn)
      address_latch_strobe_sel |-> (st_ff.ctrl[CTL_MUX_LSB +: 2] != MUX_NONE))
      else $error("latch strobes without multiplexing");

   ////////////////////////////////////////////////////////////////////////
   // Summary flags must also drop; buffer flags follow reads and takes; underflow must hold
   a_ibf_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (slave_mode && !(&st_ff.in_full)) |-> !status_word[BIT_IBF])
      else $error("all-full shown while a buffer empty");
   a_obe_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (slave_mode && !(&st_ff.out_empty)) |-> !status_word[BIT_OBE])
      else $error("all-empty shown while a buffer loaded");
   a_in_drain: assert property (@(posedge pclk) disable iff (!presetn)
      (apb_rd && paddr == OFS_IN_DATA && !(slave_mode && m_wr)) |=> !st_ff.in_full[$past(in_rd_idx)])
      else $error("input full not cleared by read");
   a_out_take: assert property (@(posedge pclk) disable iff (!presetn)
      (slave_mode && m_rd && !st_ff.out_empty[m_addr]) |=> st_ff.out_empty[$past(m_addr)])
      else $error("output empty not set when taken");
   a_unf_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      (st_ff.out_unf && !(apb_wr && paddr == OFS_STATUS)) |=> st_ff.out_unf)
      else $error("underflow dropped");

   ////////////////////////////////////////////////////////////////////////
   // Bus answer and interrupt line
   a_ready_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable) |-> pready)
      else $error("wait state inserted");
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && paddr > OFS_IRQ_MASK) |-> pslverr)
      else $error("unmapped access not refused");
   a_ovf_event: assert property (@(posedge pclk) disable iff (!presetn)
      (slave_mode && m_wr && st_ff.in_full[m_addr]) |=> st_ff.irq_stat[0])
      else $error("overflow event not latched");
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      (st_ff.irq_stat[0] && st_ff.irq_mask[0]) |-> irq)
      else $error("interrupt line low with pending event");
endmodule : ppsb_top
`default_nettype wire

// ===== pkg/ppsb_pkg.sv
// Purpose: Constants for the parallel port pin enable and slave buffer block
// Assumes: APB slave, 32-bit words, 100 MHz pclk
// Notes: Offsets are byte addresses, one aligned word per register
// Behaviour
// - Pin 14 port-owned when high select enabled
// - Pin enables 10..2 give pins to port
// - Enables 1..0 give pins 1,0 to port
// - Chip-select field picks address14 or select
// - Multiplex mode picks address or latch strobes
// - Status flags reported only in slave modes
// - Bit 15 set when all inputs full
// - Write to full input sets overflow, sticky
// - Input full flags clear on buffer read
// - Bit 7 set when all outputs empty
// - Read of empty output sets underflow, sticky
// - Output empty clears on write until taken
package ppsb_pkg;
   localparam logic [11:0] OFS_PIN_ENABLE = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_CONTROL = 12'h008;
   localparam logic [11:0] OFS_IN_DATA = 12'h010;
   localparam logic [11:0] OFS_OUT_DATA = 12'h014;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h018;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h01c;
   localparam int NBUF = 4;
   localparam int BIT_HIGH_SELECT_PIN_ENABLE = 14;
   localparam int BIT_IBF = 15;
   localparam int BIT_INPUT_OVERFLOW = 14;
   localparam int BIT_OBE = 7;
   localparam int BIT_OUTPUT_UNDERFLOW = 6;
   localparam logic [31:0] PIN_ENABLE_MASK = 32'h0000_47ff;
   localparam logic [31:0] PIN_ENABLE_RESET = 32'h0000_0000;
   localparam logic [31:0] STATUS_RESET = 32'h0000_008f;
   // Control: [1:0] mode, [3:2] multiplex, [5:4] cs function
   localparam int CTL_MODE_LSB = 0;
   localparam int CTL_MUX_LSB = 2;
   localparam int CTL_CSF_LSB = 4;
   localparam logic [31:0] CONTROL_MASK = 32'h0000_003f;
   localparam logic [1:0] MODE_MASTER = 2'h0;
   localparam logic [1:0] MODE_SLAVE_LEGACY = 2'h1;
   localparam logic [1:0] MODE_SLAVE_BUFFERED = 2'h2;
   localparam logic [1:0] MODE_SLAVE_ADDRESSED = 2'h3;
   localparam logic [1:0] MUX_NONE = 2'h0;
   localparam logic [1:0] CSF_ADDR14 = 2'h0;
   // Interrupt bits: 0 overflow, 1 underflow, 2 input written, 3 output taken
   localparam logic [3:0] IRQ_MASK_BITS = 4'hf;
endpackage : ppsb_pkg

// ===== hdl/ppsb_pin_mux.sv
// Purpose: Hands address-capable pins to the port or general I/O
// Assumes: Fields come straight from registers
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
module ppsb_pin_mux (
   input wire logic [31:0] pin_enable,
   input wire logic [1:0] chip_select_function,
   input wire logic [1:0] address_data_multiplex_mode,
   output logic [15:0] pin_to_port,
   output logic address_line_fourteen_sel,
   output logic chip_select_one_sel,
   output logic address_latch_strobe_sel
);
   import ppsb_pkg::*;
   always_comb begin
      pin_to_port = 16'h0000;
      pin_to_port[14] = pin_enable[BIT_HIGH_SELECT_PIN_ENABLE];
      pin_to_port[10:2] = pin_enable[10:2];
      pin_to_port[1:0] = pin_enable[1:0];
      address_line_fourteen_sel = pin_enable[BIT_HIGH_SELECT_PIN_ENABLE] && (chip_select_function == CSF_ADDR14);
      chip_select_one_sel = pin_enable[BIT_HIGH_SELECT_PIN_ENABLE] && (chip_select_function != CSF_ADDR14);
      // Latch strobes only make sense when address and data share pins
      address_latch_strobe_sel = (|pin_enable[1:0]) && (address_data_multiplex_mode != MUX_NONE);
   end
endmodule : ppsb_pin_mux
`default_nettype wire

// ===== test/ppsb_ext_master.sv
// Purpose: External parallel master that writes input bytes and reads output bytes
// Assumes: Strobes are levels sampled by the block after two flops
// Notes: Data lines are inverted once, one cycle after each strobe release and at the start of each read
`timescale 1ns/1ps
`default_nettype none
module ppsb_ext_master (
   input wire logic pclk,
   output logic pm_wr_strobe,
   output logic pm_rd_strobe,
   output logic [1:0] pm_addr,
   output logic [7:0] pm_wdata,
   input wire logic [7:0] pm_rdata
);
   initial begin
      pm_wr_strobe = 1'b0;
      pm_rd_strobe = 1'b0;
      pm_addr = 2'h0;
      pm_wdata = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Slow setup stretches address hold before the strobe rises
   task automatic access(input logic wr, input logic [1:0] a, input logic [7:0] d, input int slow,
                         output logic [7:0] q);
      @(posedge pclk);
      pm_addr <= a;
      pm_wdata <= wr ? d : ~pm_wdata;
      repeat (3 + slow) @(posedge pclk);
      if (wr) begin
         pm_wr_strobe <= 1'b1;
      end else begin
         pm_rd_strobe <= 1'b1;
      end
      repeat (6) @(posedge pclk);
      q = pm_rdata;
      pm_wr_strobe <= 1'b0;
      pm_rd_strobe <= 1'b0;
      @(posedge pclk);
      // Released bus must not look like held data
      pm_wdata <= ~pm_wdata;
      repeat (2) @(posedge pclk);
   endtask : access
endmodule : ppsb_ext_master
`default_nettype wire

// ===== test/ppsb_top_bench.sv
// Purpose: Self-checking bench for pin enables and slave buffer status
// Assumes: Zero-wait APB slave, external master model on the byte port
// Notes: Expected status rebuilt from tracked buffer state
`timescale 1ns/1ps
`default_nettype none
module ppsb_top_bench;
   import ppsb_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic pm_wr_strobe, pm_rd_strobe, a14_sel, cs1_sel, als_sel;
   logic [1:0] pm_addr;
   logic [7:0] pm_wdata, pm_rdata, q;
   logic [15:0] pin_to_port;
   logic [3:0] ib, ob;
   logic ov, uf;
   logic [7:0] bytes [4];
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   ppsb_top ppsb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pm_wr_strobe(pm_wr_strobe), .pm_rd_strobe(pm_rd_strobe), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
      .pm_rdata(pm_rdata), .pin_to_port(pin_to_port), .address_line_fourteen_sel(a14_sel),
      .chip_select_one_sel(cs1_sel), .address_latch_strobe_sel(als_sel), .irq(irq));
   ppsb_ext_master ppsb_ext_master_i (.pclk(pclk), .pm_wr_strobe(pm_wr_strobe), .pm_rd_strobe(pm_rd_strobe),
      .pm_addr(pm_addr), .pm_wdata(pm_wdata), .pm_rdata(pm_rdata));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out
   // Ceiling well above the roughly 750 cycles the tests need
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x) begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, s, x);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 100) begin
         n++;
         @(posedge pclk);
      end
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [31:0] stat_exp();
      return {16'h0, &ib, ov, 2'b00, ib, &ob, uf, 2'b00, ob};
   endfunction : stat_exp
   task automatic chk_stat();
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, stat_exp());
   endtask : chk_stat
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      void'($urandom(22008));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, OFS_PIN_ENABLE, 32'h0);
      chk(rd, PIN_ENABLE_RESET);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         v = (i == 5) ? 32'hffff_ffff : $urandom();
         apb(1'b1, OFS_PIN_ENABLE, v);
         apb(1'b0, OFS_PIN_ENABLE, 32'h0);
         chk(rd, v & PIN_ENABLE_MASK);
         chk({16'h0, pin_to_port}, v & PIN_ENABLE_MASK);
      end
      $display("test pin enables done");
      apb(1'b1, OFS_PIN_ENABLE, 32'h0000_4003);
      for (int i = 0; i < 64; i++) begin
         apb(1'b1, OFS_CONTROL, i);
         @(posedge pclk);
         chk({29'h0, a14_sel, cs1_sel, als_sel}, {29'h0, i[5:4] == 2'h0, i[5:4] != 2'h0, i[3:2] != 2'h0});
         apb(1'b0, OFS_STATUS, 32'h0);
         chk(rd, (i[1:0] == MODE_MASTER) ? 32'h0 : STATUS_RESET);
      end
      $display("test pin functions and modes done");
      apb(1'b1, OFS_CONTROL, {30'h0, MODE_SLAVE_BUFFERED});
      apb(1'b1, OFS_IRQ_MASK, 32'h0);
      {ib, ov, ob, uf} = {4'h0, 1'b0, 4'hf, 1'b0};
      for (int k = 0; k < 4; k++) begin
         bytes[k] = 8'($urandom());
         ppsb_ext_master_i.access(1'b1, k[1:0], bytes[k], k, q);
         ib[k] = 1'b1;
         chk_stat();
      end
      ppsb_ext_master_i.access(1'b1, 2'h2, 8'h5a, 0, q);
      ov = 1'b1;
      chk_stat();
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      for (int k = 0; k < 4; k++) begin
         apb(1'b0, OFS_IN_DATA, {22'h0, k[1:0], 8'h0});
         chk({24'h0, rd[7:0]}, {24'h0, bytes[k]});
         ib[k] = 1'b0;
         chk_stat();
      end
      apb(1'b1, OFS_STATUS, ~32'h0000_4000);
      ov = 1'b0;
      chk_stat();
      apb(1'b1, OFS_IRQ_STAT, 32'h1);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      $display("test input buffers done");
      for (int k = 0; k < 4; k++) begin
         bytes[k] = 8'($urandom());
         apb(1'b1, OFS_OUT_DATA, {22'h0, k[1:0], bytes[k]});
         ob[k] = 1'b0;
         chk_stat();
      end
      for (int k = 3; k >= 0; k--) begin
         ppsb_ext_master_i.access(1'b0, k[1:0], 8'h00, k, q);
         chk({24'h0, q}, {24'h0, bytes[k]});
         ob[k] = 1'b1;
         chk_stat();
      end
      ppsb_ext_master_i.access(1'b0, 2'h1, 8'h00, 0, q);
      uf = 1'b1;
      chk_stat();
      apb(1'b1, OFS_STATUS, ~32'h0000_0040);
      uf = 1'b0;
      chk_stat();
      $display("test output buffers done");
      apb(1'b0, 12'h020, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, e}, 32'h1);
      $display("test unmapped access done");
      close_out();
   end
endmodule : ppsb_top_bench
`default_nettype wire
